// ---- design/dsp_pkg.sv ----
/*
 * Constants, operation codes and the product shifter shared by the
 * multiply-accumulate datapath and its multiplier.
 * Assumes the instruction sequencer decodes one operation per cycle and
 * the data RAM returns the addressed word in the same cycle.
 */
// How it works
// RULE1: a move copies the addressed on-chip word to the next higher address.
// RULE2: the auxiliary register update completes in the same cycle as the move.
// RULE3: the move address simply increments, crossing RAM block boundaries freely.
// RULE4: software never asks for a move on an off-chip operand.
// RULE5: the multiply-accumulate-with-move does accumulate, multiply and move at once.
// RULE6: signed 16 by 16 multiply gives a full 32-bit product in one cycle.
// RULE7: the unsigned multiply treats both operands as unsigned.
// RULE8: one factor is the temporary operand register; result goes to the product register.
// RULE9: software moves the product to the accumulator before the next multiply.
// RULE10: multiply-accumulate adds the product, then multiplies data and program words.
// RULE11: a program operand from block zero needs block zero set as program memory.
// RULE12: back-to-back multiply-accumulates each take a single cycle.
// RULE13: square-add or square-subtract folds the product then squares the data word.
// RULE14: the shift field shifts only the path to the accumulator, not the product.
// RULE15: sixteen conditional subtracts leave quotient low and remainder high.
// RULE16: a non-negative difference is kept and shifted with a one; otherwise plain shift.
// RULE17: software divides absolute values and fixes the quotient sign itself.
// RULE18: the divisor is shifted left fifteen before each subtract.
// RULE19: shift field 11 shifts the product right six with sign extension.
// RULE20: the move writes a cycle after the read, so arithmetic sees the unmoved word.
package dsp_pkg;

	// ==========================================================
	// Widths and counts
	localparam int WORD_W           = 16;
	localparam int ACC_W            = 32;
	localparam int DIVISOR_SHIFT    = 15;
	localparam int DIVIDE_STEPS     = 16;
	localparam int RIGHT_SHIFT_BITS = 6;
	localparam int LEFT_SHIFT_WIDE  = 4;

	// ==========================================================
	// Reset values and shift field codes
	localparam logic [ACC_W-1:0]  ACC_RESET   = 32'h0000_0000;
	localparam logic [WORD_W-1:0] WORD_RESET  = 16'h0000;
	localparam logic [1:0]        SHIFT_NONE  = 2'h0;
	localparam logic [1:0]        SHIFT_LEFT1 = 2'h1;
	localparam logic [1:0]        SHIFT_LEFT4 = 2'h2;
	localparam logic [1:0]        SHIFT_RIGHT = 2'h3;

	// ==========================================================
	// Operations issued by the sequencer
	typedef enum logic [3:0] {
		op_none,
		op_load_temp,
		op_load_acc,
		op_add_product,
		multiply_op,
		unsigned_multiply_op,
		mult_acc_op,
		mult_acc_with_move_op,
		delay_move_op,
		square_add_op,
		square_subtract_op,
		conditional_subtract_op
	} op_t;

	// Product as seen on its way to the accumulator
	function automatic logic [ACC_W-1:0] shift_product(input logic [ACC_W-1:0] p, input logic [1:0] mode);
		logic [ACC_W-1:0] r;
		r = p;
		unique case (mode)
			SHIFT_NONE:  r = p;
			SHIFT_LEFT1: r = {p[ACC_W-2:0], 1'b0};
			SHIFT_LEFT4: r = {p[ACC_W-LEFT_SHIFT_WIDE-1:0], 4'h0};
			SHIFT_RIGHT: r = ACC_W'($signed(p) >>> RIGHT_SHIFT_BITS);
		endcase
		return r;
	endfunction

	// Operations that also perform the delay-line move
	function automatic logic is_move(input op_t op);
		return (op == delay_move_op) || (op == mult_acc_with_move_op);
	endfunction

endpackage

// ---- design/mult_if.sv ----
/*
 * Operand and product bundle between the datapath and its multiplier.
 * Assumes both ends sit on the same clock; the path is combinational.
 */
interface mult_if;
	import dsp_pkg::*;

	// ==========================================================
	// Operands, mode and product
	logic [WORD_W-1:0] factor_a;
	logic [WORD_W-1:0] factor_b;
	logic              unsigned_mode;
	logic [ACC_W-1:0]  product;

	modport requester (output factor_a, output factor_b, output unsigned_mode, input product);
	modport unit      (input factor_a, input factor_b, input unsigned_mode, output product);
endinterface

// ---- design/mult_unit.sv ----
/*
 * Single-cycle 16 by 16 multiplier, signed or unsigned.
 * Assumes the requester holds operands stable for the whole cycle.
 */
module mult_unit
	import dsp_pkg::*;
(
	mult_if.unit port_m
);

	// ==========================================================
	// Multiply
	logic signed [WORD_W:0]     ext_a;
	logic signed [WORD_W:0]     ext_b;
	logic signed [2*WORD_W+1:0] full;

	// One extra bit per factor lets one signed multiplier serve both modes
	assign ext_a = {port_m.unsigned_mode ? 1'b0 : port_m.factor_a[WORD_W-1], port_m.factor_a}; // RULE7
	assign ext_b = {port_m.unsigned_mode ? 1'b0 : port_m.factor_b[WORD_W-1], port_m.factor_b}; // RULE7
	assign full  = ext_a * ext_b;
	assign port_m.product = full[ACC_W-1:0]; // RULE6

endmodule

// ---- design/mac_datapath.sv ----
/*
 * Multiply-accumulate datapath: multiplies, multiply-accumulate, squares,
 * the delay-line move and the conditional-subtract divide step.
 * Assumes the sequencer presents one operation per cycle together with the
 * addressed data word, the program word and the shift field; all inputs
 * come from logic on ref_clk_in.
 */
module mac_datapath
	import dsp_pkg::*;
#(
	parameter int ADDR_W = 16
) (
	input  logic              ref_clk_in,
	input  logic              rst_in,
	input  logic              op_valid_in,
	input  op_t               op_in,
	input  logic [WORD_W-1:0] data_word_in,
	input  logic [WORD_W-1:0] prog_word_in,
	input  logic [ADDR_W-1:0] data_addr_in,
	input  logic              onchip_in,
	input  logic              prog_from_block_zero_in,
	input  logic              block_zero_is_prog_in,
	input  logic [1:0]        product_shift_field_in,
	input  logic [ACC_W-1:0]  acc_load_in,
	input  logic              aux_update_in,
	input  logic [ADDR_W-1:0] aux_reg_in,
	input  logic [ADDR_W-1:0] aux_step_in,
	output logic [ACC_W-1:0]  acc_out,
	output logic [ACC_W-1:0]  product_reg_out,
	output logic [WORD_W-1:0] temporary_operand_reg_out,
	output logic              move_we_out,
	output logic [ADDR_W-1:0] move_addr_out,
	output logic [WORD_W-1:0] move_data_out,
	output logic [ADDR_W-1:0] aux_reg_out,
	output logic              operand_fault_out
);

	// ==========================================================
	// State
	logic [ACC_W-1:0]  acc;
	logic [ACC_W-1:0]  product_reg;
	logic [WORD_W-1:0] temporary_operand_reg;
	logic [ACC_W-1:0]  shifted_product;
	logic [ACC_W:0]    sub_diff;
	logic              go;
	logic              mac_allowed;
	logic              is_mac;

	mult_if mul ();

	mult_unit u_mult (
		.port_m (mul.unit)
	);

	// ==========================================================
	// Decode
	assign go              = op_valid_in;
	assign is_mac          = (op_in == mult_acc_op) || (op_in == mult_acc_with_move_op);
	assign mac_allowed     = !(prog_from_block_zero_in && !block_zero_is_prog_in); // RULE11
	assign shifted_product = shift_product(product_reg, product_shift_field_in); // RULE14 RULE19
	// Divisor shifted left fifteen bits before the trial subtract
	assign sub_diff        = {1'b0, acc} - {2'b00, data_word_in, 15'h0000}; // RULE18

	// Factor selection: squares use the data word twice, MAC uses the program word
	always_comb begin
		mul.factor_a      = temporary_operand_reg; // RULE8
		mul.factor_b      = data_word_in;
		mul.unsigned_mode = (op_in == unsigned_multiply_op); // RULE7
		if (is_mac) begin
			mul.factor_a = prog_word_in; // RULE10
		end else if (op_in == square_add_op || op_in == square_subtract_op) begin
			mul.factor_a = data_word_in; // RULE13
		end
	end

	// ==========================================================
	// Accumulator
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			acc <= ACC_RESET;
		end else if (go) begin
			unique case (op_in)
				op_load_acc:    acc <= acc_load_in;
				op_add_product: acc <= acc + shifted_product;
				mult_acc_op, mult_acc_with_move_op: begin
					if (mac_allowed) begin
						acc <= acc + shifted_product; // RULE10 RULE5 RULE12
					end
				end
				square_add_op:      acc <= acc + shifted_product; // RULE13
				square_subtract_op: acc <= acc - shifted_product; // RULE13
				conditional_subtract_op: begin
					if (!sub_diff[ACC_W]) begin
						acc <= {sub_diff[ACC_W-2:0], 1'b1}; // RULE16 RULE15
					end else begin
						acc <= {acc[ACC_W-2:0], 1'b0}; // RULE16
					end
				end
				default: acc <= acc;
			endcase
		end
	end

	// ==========================================================
	// Product register, always stored unshifted
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			product_reg <= ACC_RESET;
		end else if (go) begin
			unique case (op_in)
				multiply_op, unsigned_multiply_op: product_reg <= mul.product; // RULE6 RULE8
				mult_acc_op, mult_acc_with_move_op: begin
					if (mac_allowed) begin
						product_reg <= mul.product; // RULE10 RULE5
					end
				end
				square_add_op, square_subtract_op: product_reg <= mul.product; // RULE13
				default: product_reg <= product_reg;
			endcase
		end
	end

	// ==========================================================
	// Temporary operand register; MAC leaves its program word there
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			temporary_operand_reg <= WORD_RESET;
		end else if (go && op_in == op_load_temp) begin
			temporary_operand_reg <= data_word_in;
		end else if (go && is_mac && mac_allowed) begin
			temporary_operand_reg <= prog_word_in;
		end
	end

	// ==========================================================
	// Delay-line move: registered write lands after the read has been used
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			move_we_out   <= 1'b0;
			move_addr_out <= '0;
			move_data_out <= WORD_RESET;
		end else begin
			move_we_out   <= go && is_move(op_in) && onchip_in
				&& !(op_in == mult_acc_with_move_op && !mac_allowed); // RULE1 RULE20 RULE4
			move_addr_out <= data_addr_in + ADDR_W'(1); // RULE3
			move_data_out <= data_word_in; // RULE1
		end
	end

	// ==========================================================
	// Auxiliary register update alongside the move
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			aux_reg_out <= '0;
		end else if (go && aux_update_in) begin
			aux_reg_out <= aux_reg_in + aux_step_in; // RULE2
		end
	end

	// Flags a MAC whose program operand sits in block zero configured as data
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			operand_fault_out <= 1'b0;
		end else begin
			operand_fault_out <= go && is_mac && !mac_allowed; // RULE11
		end
	end

	assign acc_out                   = acc;
	assign product_reg_out           = product_reg;
	assign temporary_operand_reg_out = temporary_operand_reg;

	// ==========================================================
	// Checks
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);

	sequence s_mac_issue;
		go && op_in == mult_acc_op && mac_allowed;
	endsequence

	sequence s_move_issue;
		go && is_move(op_in) && onchip_in && mac_allowed;
	endsequence

	property p_move_write;
		s_move_issue |=> move_we_out && move_addr_out == $past(data_addr_in) + ADDR_W'(1)
			&& move_data_out == $past(data_word_in);
	endproperty
	a_move_write: assert property (p_move_write) else $error("move write wrong"); // RULE1 RULE3 RULE20

	property p_no_offchip_move;
		go && !onchip_in |=> !move_we_out;
	endproperty
	a_no_offchip_move: assert property (p_no_offchip_move) else $error("off-chip move"); // RULE4

	property p_aux;
		go && aux_update_in |=> aux_reg_out == $past(aux_reg_in) + $past(aux_step_in);
	endproperty
	a_aux: assert property (p_aux) else $error("aux update wrong"); // RULE2

	property p_signed_mul;
		go && op_in == multiply_op |=>
			product_reg == ACC_W'($signed($past(temporary_operand_reg)) * $signed($past(data_word_in)));
	endproperty
	a_signed_mul: assert property (p_signed_mul) else $error("signed product wrong"); // RULE6 RULE8

	property p_unsigned_mul;
		go && op_in == unsigned_multiply_op |=>
			product_reg == ACC_W'({16'h0000, $past(temporary_operand_reg)} * {16'h0000, $past(data_word_in)});
	endproperty
	a_unsigned_mul: assert property (p_unsigned_mul) else $error("unsigned product wrong"); // RULE7

	property p_mac_back_to_back;
		s_mac_issue ##1 s_mac_issue |=> acc == $past(acc, 2)
			+ shift_product($past(product_reg, 2), $past(product_shift_field_in, 2))
			+ shift_product($past(product_reg), $past(product_shift_field_in));
	endproperty
	a_mac_back_to_back: assert property (p_mac_back_to_back) else $error("MAC chain wrong"); // RULE10 RULE12

	property p_square_sub;
		go && op_in == square_subtract_op |=> acc == $past(acc) - $past(shifted_product)
			&& product_reg == ACC_W'($signed($past(data_word_in)) * $signed($past(data_word_in)));
	endproperty
	a_square_sub: assert property (p_square_sub) else $error("square subtract wrong"); // RULE13

	property p_right_shift;
		go && op_in == op_add_product && product_shift_field_in == SHIFT_RIGHT |=>
			acc == $past(acc) + ACC_W'($signed($past(product_reg)) >>> 6) && $stable(product_reg);
	endproperty
	a_right_shift: assert property (p_right_shift) else $error("product right shift wrong"); // RULE14 RULE19

	// Kept difference or plain shift, both exactly one accumulator wide
	property p_conditional_subtract_op;
		go && op_in == conditional_subtract_op |=> acc ==
			(($past(acc) >= {1'b0, $past(data_word_in), 15'h0000})
			? {31'($past(acc) - {1'b0, $past(data_word_in), 15'h0000}), 1'b1}
			: {$past(acc[ACC_W-2:0]), 1'b0});
	endproperty
	a_conditional_subtract_op: assert property (p_conditional_subtract_op) else $error("divide step wrong"); // RULE16 RULE18

	property p_fault;
		go && is_mac && !mac_allowed |=> operand_fault_out && $stable(product_reg) && $stable(acc);
	endproperty
	a_fault: assert property (p_fault) else $error("block zero operand not refused"); // RULE11

endmodule

// ---- verification/data_ram_model.sv ----
/*
 * Behavioural on-chip data RAM that stands beside the datapath.
 * Assumes one clock; reads answer at once, the move write lands on the
 * rising edge on which the datapath's write strobe is high.
 */
module data_ram_model
	import dsp_pkg::*;
#(
	parameter int ADDR_W = 16
) (
	input  wire logic              ref_clk_in,
	input  wire logic [ADDR_W-1:0] addr_in,
	input  wire logic              we_in,
	input  wire logic [ADDR_W-1:0] waddr_in,
	input  wire logic [WORD_W-1:0] wdata_in,
	output logic      [WORD_W-1:0] rdata_out
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [WORD_W-1:0] mem [0:(1<<ADDR_W)-1];

	// ==========================================================
	// Unwritten places hold a pattern, never a stale word
	initial begin
		for (int k = 0; k < (1 << ADDR_W); k++)
			mem[k] = WORD_W'(~k);
	end

	// Read path answers at once
	assign rdata_out = mem[addr_in];

	// Write path: only on-chip moves ever reach this RAM
	always @(posedge ref_clk_in) begin
		if (we_in === 1'b1)
			mem[waddr_in] <= wdata_in;
	end
endmodule

// ---- verification/mac_datamove_divide_datapath_bench.sv ----
/*
 * Self-checking bench for the multiply-accumulate datapath.
 * Assumes the data RAM model feeds the data word; inputs change at the
 * falling edge and every operation shows its result one cycle later.
 */
module mac_datamove_divide_datapath_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import dsp_pkg::*;

	logic ref_clk_in = 0, rst_in = 1, op_valid_in = 0, onchip_in = 1, aux_update_in = 0;
	logic prog_from_block_zero_in = 0, block_zero_is_prog_in = 1;
	op_t  op_in = op_none;
	logic [15:0] data_word_in, prog_word_in = 0, data_addr_in = 0, aux_reg_in = 0, aux_step_in = 0;
	logic [15:0] temporary_operand_reg_out, move_data_out, move_addr_out, aux_reg_out, e_tmp, e_aux, dv;
	logic [15:0] orig_lo, orig_hi;
	logic [1:0]  product_shift_field_in = 0;
	logic [31:0] acc_load_in = 0, acc_out, product_reg_out, e_acc, e_prod, df;
	logic        move_we_out, operand_fault_out, flt;
	integer      seed = 59377, n_mismatch = 0, comparisons = 0, i, m;

	mac_datapath mac_datapath_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .op_valid_in(op_valid_in),
		.op_in(op_in), .data_word_in(data_word_in), .prog_word_in(prog_word_in), .data_addr_in(data_addr_in),
		.onchip_in(onchip_in), .prog_from_block_zero_in(prog_from_block_zero_in),
		.block_zero_is_prog_in(block_zero_is_prog_in), .product_shift_field_in(product_shift_field_in),
		.acc_load_in(acc_load_in), .aux_update_in(aux_update_in), .aux_reg_in(aux_reg_in),
		.aux_step_in(aux_step_in), .acc_out(acc_out), .product_reg_out(product_reg_out),
		.temporary_operand_reg_out(temporary_operand_reg_out), .move_we_out(move_we_out),
		.move_addr_out(move_addr_out), .move_data_out(move_data_out), .aux_reg_out(aux_reg_out),
		.operand_fault_out(operand_fault_out));
	data_ram_model data_ram_model_i (.ref_clk_in(ref_clk_in), .addr_in(data_addr_in), .we_in(move_we_out),
		.waddr_in(move_addr_out), .wdata_in(move_data_out), .rdata_out(data_word_in));

	// ==========================================================
	// Clock, hang guard and result checks
	initial forever #4 ref_clk_in = ~ref_clk_in;
	initial begin
		#400000;
		n_mismatch++;
		wrap_up();
	end

	task automatic wrap_up();
		if (n_mismatch == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk_word(string what, logic [31:0] e, logic [31:0] g);
		comparisons++;
		if (e !== g) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic chk_flag(string what, logic e, logic g);
		chk_word(what, {31'h0, e}, {31'h0, g});
	endtask

	// Product on its way to the accumulator; the product itself is unchanged
	function automatic logic [31:0] sh(logic [31:0] p, logic [1:0] md);
		case (md)
			2'h1: return p << 1;
			2'h2: return p << 4;
			2'h3: return 32'($signed(p) >>> 6);
			default: return p;
		endcase
	endfunction

	// ==========================================================
	// One operation: drive at the falling edge, predict, check next cycle
	task automatic run(op_t o, logic [15:0] a, logic [15:0] p);
		logic [15:0] d;
		logic        mv;
		op_valid_in = 1;
		op_in = o;
		data_addr_in = a;
		prog_word_in = p;
		#1 d = data_word_in;
		flt = (o == mult_acc_op || o == mult_acc_with_move_op) && prog_from_block_zero_in && !block_zero_is_prog_in;
		mv = (o == delay_move_op || o == mult_acc_with_move_op) && onchip_in && !flt;
		if (aux_update_in)
			e_aux = aux_reg_in + aux_step_in;
		case (o)
			op_load_temp: e_tmp = d;
			op_load_acc: e_acc = acc_load_in;
			op_add_product: e_acc += sh(e_prod, product_shift_field_in);
			multiply_op: e_prod = $signed(e_tmp) * $signed(d);
			unsigned_multiply_op: e_prod = e_tmp * d;
			mult_acc_op, mult_acc_with_move_op: if (!flt) begin
				e_acc += sh(e_prod, product_shift_field_in);
				e_prod = $signed(p) * $signed(d);
				e_tmp = p;
			end
			square_add_op, square_subtract_op: begin
				e_acc = (o == square_add_op) ? e_acc + sh(e_prod, product_shift_field_in)
				                             : e_acc - sh(e_prod, product_shift_field_in);
				e_prod = $signed(d) * $signed(d);
			end
			conditional_subtract_op: begin
				df = e_acc - ({16'h0, d} << 15);
				e_acc = df[31] ? {e_acc[30:0], 1'b0} : {df[30:0], 1'b1};
			end
			default: ;
		endcase
		@(negedge ref_clk_in);
		chk_word("acc", e_acc, acc_out);
		chk_word("product", e_prod, product_reg_out);
		chk_word("temp", {16'h0, e_tmp}, {16'h0, temporary_operand_reg_out});
		chk_word("aux", {16'h0, e_aux}, {16'h0, aux_reg_out});
		chk_flag("fault", flt, operand_fault_out);
		chk_flag("move_we", mv, move_we_out);
		if (mv) begin
			chk_word("move_addr", {16'h0, a + 16'h1}, {16'h0, move_addr_out});
			chk_word("move_data", {16'h0, d}, {16'h0, move_data_out});
		end
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		e_acc = 0;
		e_prod = 0;
		e_tmp = 0;
		e_aux = 0;
		repeat (12) @(negedge ref_clk_in);
		rst_in = 0;
		for (i = 0; i < 16; i++) begin
			data_ram_model_i.mem[16'h200 + i] = (i == 0) ? 16'h8000 : 16'($random(seed));
			data_ram_model_i.mem[16'h2f8 + i] = 16'($random(seed));
		end
		run(op_none, 16'h200, 16'h0);
		// Signed and unsigned multiplies, the most negative word first
		for (i = 0; i < 8; i++) begin
			run(op_load_temp, 16'h200 + 16'(i), 16'h0);
			run(multiply_op, 16'h200 + 16'(i), 16'h0);
			run(op_add_product, 16'h200, 16'h0);
			run(unsigned_multiply_op, 16'h201 + 16'(i), 16'h0);
		end
		// Every product shift mode, product register left unshifted
		for (m = 0; m < 4; m++) begin
			product_shift_field_in = 2'(m);
			acc_load_in = 32'($random(seed));
			run(op_load_acc, 16'h200, 16'h0);
			run(op_add_product, 16'h200, 16'h0);
			run(square_add_op, 16'h203 + 16'(m), 16'h0);
			run(square_subtract_op, 16'h204 + 16'(m), 16'h0);
		end
		// Back-to-back multiply-accumulates, then two refused block-zero fetches
		prog_from_block_zero_in = 1;
		for (i = 0; i < 6; i++)
			run(mult_acc_op, 16'h205 + 16'(i), 16'($random(seed)));
		block_zero_is_prog_in = 0;
		run(mult_acc_op, 16'h209, 16'h1234);
		run(mult_acc_with_move_op, 16'h20a, 16'h1234);
		block_zero_is_prog_in = 1;
		// Delay line walking down across a block edge with aux updates
		orig_lo = data_ram_model_i.mem[16'h2ff];
		orig_hi = data_ram_model_i.mem[16'h2fe];
		aux_update_in = 1;
		for (i = 0; i < 6; i++) begin
			aux_reg_in = 16'h302 - 16'(i);
			aux_step_in = 16'hffff;
			run(mult_acc_with_move_op, 16'h302 - 16'(i), 16'($random(seed)));
		end
		aux_update_in = 0;
		run(delay_move_op, 16'h2fe, 16'h0);
		onchip_in = 0;
		run(delay_move_op, 16'h200, 16'h0);
		onchip_in = 1;
		run(op_none, 16'h2f9, 16'h0);
		chk_word("moved", {16'h0, orig_hi}, {16'h0, data_ram_model_i.mem[16'h2ff]});
		chk_word("moved_edge", {16'h0, orig_lo}, {16'h0, data_ram_model_i.mem[16'h300]});
		// Divides: the worked example, then random positive pairs
		for (i = 0; i < 5; i++) begin
			acc_load_in = (i == 0) ? 32'd33 : {17'h0, 15'($random(seed))};
			dv = (i == 0) ? 16'd5 : {1'b0, 15'($random(seed))} | 16'h1;
			data_ram_model_i.mem[16'h100] = dv;
			run(op_load_acc, 16'h100, 16'h0);
			repeat (16) run(conditional_subtract_op, 16'h100, 16'h0);
			chk_word("quotient", acc_load_in / dv, {16'h0, acc_out[15:0]});
			chk_word("remainder", acc_load_in % dv, {16'h0, acc_out[31:16]});
		end
		op_valid_in = 0;
		wrap_up();
	end
endmodule
